// [core/acs_consts.vh]
/*
  constants for the converter calibration sequencer: timing counts,
  select codes and the control and status register map.
  assumes inclusion by bare name from the sequencer module.
*/
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH

// ----------------------------------------
// timing counts, master-clock cycles
// ----------------------------------------
`define ACS_SELF_CAL_CYCLES 3145655
`define ACS_SYS_ZERO_CYCLES 1052599
`define ACS_SYS_GAIN_CYCLES 1068813
`define ACS_SYS_ONE_CYCLES 2117389
`define ACS_STROBE_MIN 4
`define ACS_SAMPLE_DIV 256
`define ACS_SETTLE_CYCLES 62
`define ACS_CORNER_DIV 409600
`define ACS_OSR 800

// ----------------------------------------
// select codes {first, second}
// ----------------------------------------
`define ACS_SEL_SELF 2'h0
`define ACS_SEL_SYS_GAIN 2'h1
`define ACS_SEL_SYS_ONE 2'h2
`define ACS_SEL_SYS_ZERO 2'h3

// ----------------------------------------
// register offsets and bits
// ----------------------------------------
`define ACS_REG_STATUS 4'h0
`define ACS_REG_MASK 4'h1
`define ACS_REG_STATE 4'h2
`define ACS_REG_CTRL 4'h3
`define ACS_REG_OSR_LO 4'h4
`define ACS_REG_OSR_HI 4'h5
`define ACS_EV_START 0
`define ACS_EV_DONE 1
`define ACS_EV_SHORT 2
`define ACS_EV_SAMPLE 3
`define ACS_CTRL_SAMPLE_EN 0

`endif

// [core/acs_sequencer.v]
/*
  calibration sequencer: watches the calibration strobe, latches the
  select pins, runs each calibration for its fixed cycle count, drives
  the data-ready output, and keeps the 256-cycle sample frame.
  assumes all pins synchronous to clk (the master clock) and a host
  on the plain register port.
  assumes clkEnable low freezes every register of the block.
  assumes the host keeps the strobe quiet during a running sequence;
  strobes that fall while busy or settling are dropped.
*/
// The implementer's own choices: the register addresses and the address-and-strobe port.
// How it works
// - strobe held high four or more cycles; calibration starts at its falling edge.
// - calibration type comes from both select pins when the strobe starts it.
// - both selects low: self-calibration, ground zero, reference full scale, 3145655 cycles.
// - bipolar self-calibration measures positive full scale and midscale.
// - both selects high: system zero step from the input, 1052599 cycles.
// - first low, second high: system gain step from the input, 1068813 cycles.
// - first high, second low: one-step system offset, 2117389 cycles.
// - data-ready stays high through the whole calibration.
// - after self-calibration data-ready falls once settled to the input.
// - after system steps data-ready falls as settling begins.
// - inputs are sampled once every 256 master-clock cycles.
// - filter corner is clock over 409600, oversampling ratio 800.
// - 62 cycles of settling are allowed after each sample.
// - polarity select low is unipolar, high is bipolar.
`timescale 1ns/1ns
`include "acs_consts.vh"

module acs_sequencer #(
  parameter SELF_CYCLES = `ACS_SELF_CAL_CYCLES,
  parameter ZERO_CYCLES = `ACS_SYS_ZERO_CYCLES,
  parameter GAIN_CYCLES = `ACS_SYS_GAIN_CYCLES,
  parameter ONE_CYCLES = `ACS_SYS_ONE_CYCLES,
  parameter SETTLE_CYCLES = `ACS_SETTLE_CYCLES
) (
  input wire clk,
  input wire reset,
  input wire clkEnable,
  input wire calStrobe,
  input wire cal_select_first,
  input wire cal_select_second,
  input wire polarity_select,
  input wire [3:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  output reg output_word_pending_n,
  output reg calBusy,
  output reg [1:0] calType,
  output reg zeroFromInput,
  output reg fullFromInput,
  output reg bipolarCal,
  output reg sampleStrobe,
  output reg settleWindow,
  output reg irq
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_CAL = 2'h1;
  localparam ST_SETTLE = 2'h2;

  // ----------------------------------------
  // state and counters
  // ----------------------------------------
  reg [1:0] state;
  reg prevStrobe;
  reg [2:0] highCount;
  reg [21:0] calCount;
  reg [7:0] sampleCount;
  reg [7:0] settleCount;
  reg [3:0] status;
  reg [3:0] mask;
  reg sampleEnable;
  reg [3:0] events;
  reg [21:0] calLength;
  reg [9:0] osrCount;

  // ----------------------------------------
  // qualified strobe and sequence ends
  // ----------------------------------------
  wire strobeFall = prevStrobe & ~calStrobe;
  wire strobeLong = (highCount >= 3'd`ACS_STROBE_MIN);
  wire [1:0] selNow = {cal_select_first, cal_select_second};
  wire startOk = (state == ST_IDLE) && strobeFall && strobeLong;
  wire shortSeen = strobeFall && !strobeLong;
  wire calLast = (state == ST_CAL) && (calCount == calLength - 22'h1);
  wire settleLast = (state == ST_SETTLE) && (settleCount == SETTLE_CYCLES[7:0] - 8'h1);
  wire sysDone = calLast && (calType != `ACS_SEL_SELF);

  // ----------------------------------------
  // calibration length select
  // ----------------------------------------
  always @* begin
    case (calType)
      `ACS_SEL_SELF: calLength = SELF_CYCLES[21:0];
      `ACS_SEL_SYS_ZERO: calLength = ZERO_CYCLES[21:0];
      `ACS_SEL_SYS_GAIN: calLength = GAIN_CYCLES[21:0];
      `ACS_SEL_SYS_ONE: calLength = ONE_CYCLES[21:0];
      default: calLength = SELF_CYCLES[21:0];
    endcase
  end

  // ----------------------------------------
  // strobe qualification
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      prevStrobe <= 1'b0;
      highCount <= 3'h0;
    end else if (clkEnable) begin
      prevStrobe <= calStrobe;
      if (!calStrobe) begin
        highCount <= 3'h0;
      end else if (highCount != 3'h7) begin
        highCount <= highCount + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // calibration events
  // ----------------------------------------
  always @* begin
    events = 4'h0;
    events[`ACS_EV_START] = startOk;
    events[`ACS_EV_SHORT] = shortSeen;
    events[`ACS_EV_DONE] = sysDone || settleLast;
    events[`ACS_EV_SAMPLE] = sampleStrobe;
  end

  // ----------------------------------------
  // latched selection, held for the whole sequence
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      calType <= `ACS_SEL_SELF;
      zeroFromInput <= 1'b0;
      fullFromInput <= 1'b0;
      bipolarCal <= 1'b0;
    end else if (clkEnable && startOk) begin
      calType <= selNow;
      zeroFromInput <= selNow[1];
      fullFromInput <= (selNow == `ACS_SEL_SYS_GAIN);
      // midscale only matters for the self-calibration
      bipolarCal <= polarity_select && (selNow == `ACS_SEL_SELF);
    end
  end

  // ----------------------------------------
  // sequence state and counters
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      calCount <= 22'h0;
      settleCount <= 8'h0;
      calBusy <= 1'b0;
      output_word_pending_n <= 1'b1;
    end else if (clkEnable) begin
      case (state)
        ST_IDLE: begin
          if (startOk) begin
            state <= ST_CAL;
            calCount <= 22'h0;
            calBusy <= 1'b1;
            output_word_pending_n <= 1'b1;
          end
        end
        ST_CAL: begin
          if (calLast) begin
            calBusy <= 1'b0;
            if (calType == `ACS_SEL_SELF) begin
              state <= ST_SETTLE;
              settleCount <= 8'h0;
            end else begin
              state <= ST_IDLE;
              output_word_pending_n <= 1'b0;
            end
          end else begin
            calCount <= calCount + 22'h1;
          end
        end
        ST_SETTLE: begin
          if (settleLast) begin
            state <= ST_IDLE;
            output_word_pending_n <= 1'b0;
          end else begin
            settleCount <= settleCount + 8'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // sample frame
  // ----------------------------------------
  wire frameEnd = (sampleCount == 8'hff);
  wire inSettle = (sampleCount < SETTLE_CYCLES[7:0] - 8'h1) || frameEnd;

  always @(posedge clk) begin
    if (reset) begin
      sampleCount <= 8'h0;
      sampleStrobe <= 1'b0;
      settleWindow <= 1'b0;
    end else if (clkEnable) begin
      // free-running, so the ratio holds at any clock rate
      sampleCount <= sampleCount + 8'h1;
      sampleStrobe <= sampleEnable && frameEnd;
      settleWindow <= sampleEnable && inSettle;
    end
  end

  // ----------------------------------------
  // oversampling frame, one word per ratio
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      osrCount <= 10'h000;
    end else if (clkEnable && sampleStrobe) begin
      if (osrCount == 10'd`ACS_OSR - 10'h001) begin
        osrCount <= 10'h000;
      end else begin
        osrCount <= osrCount + 10'h001;
      end
    end
  end

  // ----------------------------------------
  // sticky status bits, write one to clear
  // ----------------------------------------
  wire statusWrite = regWrite && (regAddr == `ACS_REG_STATUS);
  wire [3:0] next_status;
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < 4; bitIdx = bitIdx + 1) begin : statusBit
      // set wins over a clear in the same cycle
      assign next_status[bitIdx] = events[bitIdx] ||
        (status[bitIdx] && !(statusWrite && regWriteData[bitIdx]));
    end
  endgenerate

  // ----------------------------------------
  // control and status registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      status <= 4'h0;
      mask <= 4'h0;
      sampleEnable <= 1'b1;
    end else if (clkEnable) begin
      status <= next_status;
      if (regWrite && regAddr == `ACS_REG_MASK) begin
        mask <= regWriteData[3:0];
      end
      if (regWrite && regAddr == `ACS_REG_CTRL) begin
        sampleEnable <= regWriteData[`ACS_CTRL_SAMPLE_EN];
      end
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clkEnable) begin
      // registered, so it trails the status bit by one cycle
      irq <= |(status & mask);
    end
  end

  // ----------------------------------------
  // read back, data one cycle after the strobe
  // ----------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (clkEnable) begin
      if (regRead) begin
        case (regAddr)
          `ACS_REG_STATUS: regReadData <= {4'h0, status};
          `ACS_REG_MASK: regReadData <= {4'h0, mask};
          `ACS_REG_STATE: regReadData <= {2'h0, bipolarCal, calBusy, calType, state};
          `ACS_REG_CTRL: regReadData <= {7'h00, sampleEnable};
          `ACS_REG_OSR_LO: regReadData <= osrCount[7:0];
          `ACS_REG_OSR_HI: regReadData <= {6'h00, osrCount[9:8]};
          default: regReadData <= 8'h00;
        endcase
      end else begin
        regReadData <= 8'h00;
      end
    end
  end

endmodule

// [verification/acs_seq_props.sv]
/* checker for the calibration sequencer ports.
   assumes bind onto acs_sequencer with clkEnable held high. */
`timescale 1ns/1ns
module acs_seq_props #(
  parameter SELF_CYCLES = 40,
  parameter ZERO_CYCLES = 20,
  parameter GAIN_CYCLES = 24,
  parameter ONE_CYCLES = 30
) (
  input wire clk,
  input wire reset,
  input wire calStrobe,
  input wire cal_select_first,
  input wire cal_select_second,
  input wire output_word_pending_n,
  input wire calBusy,
  input wire [1:0] calType,
  input wire sampleStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  int busyCnt;
  wire [31:0] calLen = (calType == 2'h0) ? SELF_CYCLES : (calType == 2'h3) ? ZERO_CYCLES :
    (calType == 2'h1) ? GAIN_CYCLES : ONE_CYCLES;
  always @(posedge clk) busyCnt <= (reset || !calBusy) ? 0 : busyCnt + 1;
  AST_START: assert property (calStrobe [*4] ##1 (!calStrobe && !calBusy) |=> calBusy)
    else $error("calibration did not start");
  AST_SHORT: assert property (!calStrobe ##1 calStrobe [*3] ##1 (!calStrobe && !calBusy)
    |=> !calBusy)
    else $error("short strobe started calibration");
  AST_TYPE: assert property ($rose(calBusy) |->
    calType == $past({cal_select_first, cal_select_second}))
    else $error("wrong calibration type");
  AST_LEN: assert property ($fell(calBusy) |-> busyCnt == calLen)
    else $error("wrong calibration length");
  AST_HOLD: assert property (calBusy |-> output_word_pending_n)
    else $error("data ready low during calibration");
  AST_SYS: assert property ($fell(calBusy) && calType != 2'h0 |-> !output_word_pending_n)
    else $error("data ready late after system step");
  AST_SELF: assert property ($fell(calBusy) && calType == 2'h0 |->
    ##61 output_word_pending_n ##1 !output_word_pending_n)
    else $error("data ready timing after self calibration");
  AST_SAMPLE: assert property (sampleStrobe |-> ##256 sampleStrobe)
    else $error("sample period wrong");
endmodule
bind acs_sequencer acs_seq_props #(.SELF_CYCLES(SELF_CYCLES), .ZERO_CYCLES(ZERO_CYCLES),
  .GAIN_CYCLES(GAIN_CYCLES), .ONE_CYCLES(ONE_CYCLES)) propsU (.clk(clk), .reset(reset),
  .calStrobe(calStrobe), .cal_select_first(cal_select_first),
  .cal_select_second(cal_select_second), .output_word_pending_n(output_word_pending_n),
  .calBusy(calBusy), .calType(calType), .sampleStrobe(sampleStrobe));

// [verification/acs_host_model.sv]
/* host model: drives calibration strobe and select pins.
   assumes the bench calls cal from just after a clock edge. */
`timescale 1ns/1ns
module acs_host_model (
  input wire clk,
  output logic calStrobe,
  output logic [1:0] calSel
);
  initial begin
    calStrobe = 1'b0;
    calSel = 2'h0;
  end
  // selects steady until the low sample, then inverted
  task cal(input logic [1:0] s, input int n);
    @(posedge clk);
    calSel <= s;
    calStrobe <= 1'b1;
    repeat (n) @(posedge clk);
    calStrobe <= 1'b0;
    @(posedge clk);
    calSel <= ~s;
  endtask
endmodule

// [verification/acs_sequencer_tb_top.sv]
/* bench for the calibration sequencer.
   assumes the host model and the bound checker. */
`timescale 1ns/1ns
module acs_sequencer_tb_top;
  localparam int SL = 40, ZL = 20, GL = 24, OL = 30;
  logic clk = 1'b0, reset = 1'b1, pol = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWriteData = 8'h00, regReadData, rdData;
  logic calStrobe, pendN, calBusy, zin, fin, bip, sampleStrobe, settleWindow, irq;
  logic [1:0] calSel, calType;
  int mismatches = 0, samples_checked = 0, busyN, k;
  logic [2:0] rows [5] = '{3'h0, 3'h7, 3'h1, 3'h6, 3'h4}; // polarity, select code
  int lens [5] = '{SL, ZL, GL, OL, SL};
  always #5 clk = ~clk;
  acs_host_model hostU (.clk(clk), .calStrobe(calStrobe), .calSel(calSel));
  acs_sequencer #(.SELF_CYCLES(SL), .ZERO_CYCLES(ZL), .GAIN_CYCLES(GL), .ONE_CYCLES(OL)) dut_u (
    .clk(clk), .reset(reset), .clkEnable(1'b1), .calStrobe(calStrobe),
    .cal_select_first(calSel[1]), .cal_select_second(calSel[0]), .polarity_select(pol),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .output_word_pending_n(pendN), .calBusy(calBusy),
    .calType(calType), .zeroFromInput(zin), .fullFromInput(fin), .bipolarCal(bip),
    .sampleStrobe(sampleStrobe), .settleWindow(settleWindow), .irq(irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 rdData = regReadData;
  endtask
  task run(input logic [1:0] s, input logic p, input int len);
    @(posedge clk);
    pol <= p;
    hostU.cal(s, 4);
    busyN = 0;
    repeat (len + 70) begin
      #1;
      if (calBusy === 1'b1) busyN++;
      if (calBusy === 1'b1 && busyN == 1)
        chk({calType, zin, fin, bip}, {s, s[1], s == 2'h1, p && s == 2'h0});
      @(posedge clk);
    end
    #1 chk(busyN, len);
    chk(pendN, 1'b0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk({pendN, calBusy, irq}, 3'h4);
    rd(4'h3);
    chk(rdData, 8'h01);
    rd(4'h1);
    chk(rdData, 8'h00);
    rd(4'hf);
    chk(rdData, 8'h00);
    for (k = 0; k < 5; k++) run(rows[k][1:0], rows[k][2], lens[k]);
    @(posedge sampleStrobe);
    #1 busyN = 0;
    repeat (70) begin
      if (settleWindow === 1'b1) busyN++;
      @(posedge clk);
      #1;
    end
    chk(busyN, 62);
    wr(4'h1, 8'h04);
    wr(4'h0, 8'hff);
    hostU.cal(2'h0, 3);
    repeat (3) @(posedge clk);
    #1 chk({calBusy, irq}, 2'h1);
    rd(4'h0);
    chk(rdData[2], 1'b1);
    wr(4'h1, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    wr(4'h1, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    wr(4'h0, 8'h04);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    hostU.cal(2'h0, 4);
    hostU.cal(2'h3, 6);
    repeat (SL + 70) @(posedge clk);
    #1 chk({calType, pendN}, 3'h0);
    stop_test();
  end
endmodule
